// ==== core/dcpmc_pkg.sv ====
/*
  shared constants and types for the dual-core power mode controller.
  assumes nothing beyond a systemverilog compiler.
*/
package dcpmc_pkg;
  localparam int DCPMC_NUM_CORES = 2;
  localparam int DCPMC_SYS_MODE_W = 2;
  // system power-down selection encodings
  localparam logic [1:0] DCPMC_SEL_DEEP_SLEEP = 2'h0;
  localparam logic [1:0] DCPMC_SEL_POWER_DOWN = 2'h1;
  localparam logic [1:0] DCPMC_SEL_DEEP_PD = 2'h2;
  localparam logic [1:0] DCPMC_SEL_RESET = 2'h0;
  // memory retention per mode: 1 keeps memory powered
  localparam logic DCPMC_RET_DEEP_SLEEP = 1'h1;
  localparam logic DCPMC_RET_POWER_DOWN = 1'h1;
  localparam logic DCPMC_RET_DEEP_PD = 1'h0;
  typedef enum logic [2:0] {
    DCPMC_MODE_ACTIVE,
    DCPMC_MODE_SLEEP,
    DCPMC_MODE_DEEP_SLEEP,
    DCPMC_MODE_POWER_DOWN,
    DCPMC_MODE_DEEP_PD
  } dcpmc_mode_t;
  typedef enum logic {
    DCPMC_CORE_ACTIVE,
    DCPMC_CORE_SLEEP
  } dcpmc_core_st_t;
endpackage

// ==== core/dcpmc_core_if.sv ====
/*
  per-core carrier between the top controller and the core tracker.
  assumes one clock shared by both ends.
*/
`timescale 1ns/1ps
`default_nettype none
interface dcpmc_core_if;
  logic wait_instr;
  logic wake;
  logic pd_enable;
  logic sys_entry;
  logic sys_active;
  logic waiting;
  logic clk_en;
  modport ctrl (
    output wait_instr, wake, pd_enable, sys_entry, sys_active,
    input waiting, clk_en
  );
  modport core (
    input wait_instr, wake, pd_enable, sys_entry, sys_active,
    output waiting, clk_en
  );
endinterface
`default_nettype wire

// ==== core/dcpmc_core_track.sv ====
/*
  active/sleep tracker for one processor core.
  assumes synchronous inputs on clk_sys_in and a synchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none
module dcpmc_core_track
  import dcpmc_pkg::*;
(
  // clock, reset, enable
  input wire logic clk_sys_in,
  input wire logic srst_in,
  input wire logic ce_in,
  // controller side
  dcpmc_core_if.core cif
);
  dcpmc_core_st_t state_reg;

  // each core sleeps and wakes on its own
  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
      state_reg <= DCPMC_CORE_ACTIVE;
    else if (ce_in)
    begin
      unique case (state_reg)
        DCPMC_CORE_ACTIVE:
          if (cif.wait_instr && !cif.sys_active)
            state_reg <= DCPMC_CORE_SLEEP;
        DCPMC_CORE_SLEEP:
          // wake wins, but not while the system is powered down
          if (cif.wake && !cif.sys_active && !cif.sys_entry)
            state_reg <= DCPMC_CORE_ACTIVE;
      endcase
    end
  end

  assign cif.waiting = (state_reg == DCPMC_CORE_SLEEP) && cif.pd_enable;
  // sleeping core gets no clock, system mode stops it too
  assign cif.clk_en = (state_reg == DCPMC_CORE_ACTIVE)
    && !cif.sys_active;
endmodule
`default_nettype wire

// ==== core/dcpmc_top.sv ====
/*
  dual-core power mode controller: per-core active/sleep and system-wide
  deep-sleep, power-down and deep power-down.
  assumes all inputs synchronous to clk_sys_in; wake events come from the
  always-on domain.
*/
// Operation
// - five modes: active, sleep, deep-sleep, power-down, deep power-down
// - active or sleep is held for each core separately
// - an active core keeps its clock running
// - a sleeping core gets no clock; peripherals and memory keep running
// - either core may sleep on its own whatever the other does
// - the three power-down modes are system-wide only
// - power-down stops both cores and all non-always-on peripherals
// - memory power follows the retention of the chosen power-down mode
// - only enabled active cores may request power-down; others ignored
// - with both enabled, power-down waits for both cores' wait instructions
`timescale 1ns/1ps
`default_nettype none
module dcpmc_top
  import dcpmc_pkg::*;
#(
  parameter int NUM_CORES = DCPMC_NUM_CORES
)
(
  // clock, reset, enable
  input wire logic clk_sys_in,
  input wire logic srst_in,
  input wire logic ce_in,
  // core requests
  input wire logic [1:0] wait_for_interrupt_instruction_in,
  input wire logic [1:0] wait_for_event_instruction_in,
  input wire logic [1:0] pd_enable_in,
  input wire logic [1:0] pd_sel_core0_in,
  input wire logic [1:0] pd_sel_core1_in,
  input wire logic [1:0] wake_in,
  // clock gating and power control
  output logic [1:0] core_clk_en_out,
  output logic periph_power_en_out,
  output logic mem_power_en_out,
  output logic pd_grant_out,
  output logic [2:0] mode_out
);
  generate
    if (NUM_CORES != 2)
    begin : g_bad
      $error("dcpmc_top serves exactly two cores");
    end
  endgenerate

  dcpmc_core_if cif0 ();
  dcpmc_core_if cif1 ();
  dcpmc_mode_t mode_reg;
  logic [1:0] sel_reg;
  logic [1:0] waiting;
  logic [1:0] wait_instr;
  logic entry;
  logic any_wake;
  logic [1:0] sel_next;

  assign wait_instr = wait_for_interrupt_instruction_in
    | wait_for_event_instruction_in;
  assign any_wake = |wake_in;

  // enabled cores must all be waiting, at least one enabled
  // a pending wake blocks entry so a woken system cannot fall straight back
  assign entry = (mode_reg == DCPMC_MODE_ACTIVE
    || mode_reg == DCPMC_MODE_SLEEP)
    && !any_wake
    && (|pd_enable_in)
    && ((waiting & pd_enable_in) == pd_enable_in);

  // selection from an enabled core only; core0 first
  always_comb
  begin
    sel_next = sel_reg;
    if (pd_enable_in[0] && wait_instr[0] && core_clk_en_out[0])
      sel_next = pd_sel_core0_in;
    else if (pd_enable_in[1] && wait_instr[1] && core_clk_en_out[1])
      sel_next = pd_sel_core1_in;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
      sel_reg <= DCPMC_SEL_RESET;
    else if (ce_in)
      sel_reg <= sel_next;
  end

  assign cif0.wait_instr = wait_instr[0];
  assign cif0.wake = wake_in[0];
  assign cif0.pd_enable = pd_enable_in[0];
  assign cif0.sys_entry = entry;
  assign cif1.wait_instr = wait_instr[1];
  assign cif1.wake = wake_in[1];
  assign cif1.pd_enable = pd_enable_in[1];
  assign cif1.sys_entry = entry;
  assign cif0.sys_active = mode_reg > DCPMC_MODE_SLEEP;
  assign cif1.sys_active = mode_reg > DCPMC_MODE_SLEEP;
  assign waiting = {cif1.waiting, cif0.waiting};

  dcpmc_core_track u_core0 (
    .clk_sys_in(clk_sys_in),
    .srst_in(srst_in),
    .ce_in(ce_in),
    .cif(cif0.core)
  );

  dcpmc_core_track u_core1 (
    .clk_sys_in(clk_sys_in),
    .srst_in(srst_in),
    .ce_in(ce_in),
    .cif(cif1.core)
  );

  // system mode
  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
      mode_reg <= DCPMC_MODE_ACTIVE;
    else if (ce_in)
    begin
      unique case (mode_reg)
        DCPMC_MODE_ACTIVE, DCPMC_MODE_SLEEP:
          if (entry)
          begin
            unique case (sel_reg)
              DCPMC_SEL_POWER_DOWN: mode_reg <= DCPMC_MODE_POWER_DOWN;
              DCPMC_SEL_DEEP_PD: mode_reg <= DCPMC_MODE_DEEP_PD;
              default: mode_reg <= DCPMC_MODE_DEEP_SLEEP;
            endcase
          end
          else if (cif0.clk_en || cif1.clk_en)
            mode_reg <= DCPMC_MODE_ACTIVE;
          else
            mode_reg <= DCPMC_MODE_SLEEP;
        DCPMC_MODE_DEEP_SLEEP, DCPMC_MODE_POWER_DOWN, DCPMC_MODE_DEEP_PD:
          if (any_wake)
            mode_reg <= DCPMC_MODE_ACTIVE;
        default:
          mode_reg <= DCPMC_MODE_ACTIVE;
      endcase
    end
  end

  assign core_clk_en_out = {cif1.clk_en, cif0.clk_en};
  assign pd_grant_out = cif0.sys_active;

  always_ff @(posedge clk_sys_in)
  begin
    if (srst_in)
    begin
      periph_power_en_out <= 1'h1;
      mem_power_en_out <= 1'h1;
      mode_out <= 3'h0;
    end
    else if (ce_in)
    begin
      mode_out <= mode_reg;
      unique case (mode_reg)
        DCPMC_MODE_DEEP_SLEEP:
        begin
          periph_power_en_out <= 1'h0;
          mem_power_en_out <= DCPMC_RET_DEEP_SLEEP;
        end
        DCPMC_MODE_POWER_DOWN:
        begin
          periph_power_en_out <= 1'h0;
          mem_power_en_out <= DCPMC_RET_POWER_DOWN;
        end
        DCPMC_MODE_DEEP_PD:
        begin
          periph_power_en_out <= 1'h0;
          mem_power_en_out <= DCPMC_RET_DEEP_PD;
        end
        default:
        begin
          periph_power_en_out <= 1'h1;
          mem_power_en_out <= 1'h1;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== verification/dcpmc_assertions.sv ====
/* checker for the power mode controller ports.
   bound to every dcpmc_top instance. */
`timescale 1ns/1ps
`default_nettype none
module dcpmc_assertions (
  // watched ports
  input wire logic clk_sys_in,
  input wire logic srst_in,
  input wire logic ce_in,
  input wire logic [1:0] wait_for_interrupt_instruction_in,
  input wire logic [1:0] wait_for_event_instruction_in,
  input wire logic [1:0] pd_enable_in,
  input wire logic [1:0] wake_in,
  input wire logic [1:0] core_clk_en_out,
  input wire logic periph_power_en_out,
  input wire logic mem_power_en_out,
  input wire logic pd_grant_out,
  input wire logic [2:0] mode_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (srst_in);
  wire [1:0] wt = wait_for_interrupt_instruction_in |
    wait_for_event_instruction_in;
  sequence s_wait0;
    ce_in && wt[0] && !wake_in[0] && !pd_grant_out;
  endsequence
  sequence s_solo;
    (s_wait0 and pd_enable_in == 2'h1)
    ##1 (ce_in && pd_enable_in == 2'h1 && wake_in == 2'h0);
  endsequence
  sleep_gate_a: assert property (s_wait0 |=> !core_clk_en_out[0])
    else $error("core0 clock not stopped");
  stay_stop_a: assert property (!core_clk_en_out[0] && !wake_in[0]
    && !pd_grant_out |=> !core_clk_en_out[0]) else $error("core0 woke");
  pd_stops_a: assert property (pd_grant_out |-> core_clk_en_out == 2'h0)
    else $error("core clock on in power-down");
  periph_off_a: assert property ($rose(pd_grant_out) && ce_in
    |=> !periph_power_en_out) else $error("peripherals still powered");
  mem_keep_a: assert property (mem_power_en_out == (mode_out != 3'h4))
    else $error("memory power wrong");
  no_enable_a: assert property (pd_enable_in == 2'h0
    && $past(pd_enable_in) == 2'h0 && !pd_grant_out |=> !pd_grant_out)
    else $error("power-down without enable");
  both_wait_a: assert property (pd_enable_in == 2'h3
    && core_clk_en_out[1] && !wt[1] && !pd_grant_out |=> !pd_grant_out)
    else $error("power-down before core1 waited");
  single_pd_a: assert property (s_solo |=> pd_grant_out)
    else $error("power-down not entered");
endmodule
bind dcpmc_top dcpmc_assertions u_chk (.clk_sys_in, .srst_in, .ce_in,
  .wait_for_interrupt_instruction_in, .wait_for_event_instruction_in,
  .pd_enable_in, .wake_in, .core_clk_en_out, .periph_power_en_out,
  .mem_power_en_out, .pd_grant_out, .mode_out);
`default_nettype wire

// ==== verification/dcpmc_cores.sv ====
/* model of the two cores driving the request pins.
   applies bench commands at the falling edge. */
`timescale 1ns/1ps
`default_nettype none
module dcpmc_cores (
  // bench side
  input wire logic clk_in,
  input wire logic [11:0] cmd_in,
  // controller side
  output logic [11:0] pins_out
);
  initial pins_out = 12'h0;
  // enable and select settle together with the wait request
  always @(negedge clk_in) pins_out <= cmd_in;
endmodule
`default_nettype wire

// ==== verification/tb.sv ====
/* self-checking bench for the power mode controller.
   the core model drives every request pin. */
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_sys_in = 1'b0;
  logic srst_in = 1'b1;
  logic ce = 1'b1;
  logic [11:0] cmd = 12'h0;
  wire [11:0] pin;
  logic [1:0] clk_en;
  logic periph, mem, grant;
  logic [2:0] mode;
  int fail_count = 0;
  int checked = 0;
  // enable, select core1, select core0, mode, memory
  logic [9:0] rows [6] = '{10'h105, 10'h117, 10'h128, 10'h135, 10'h288,
    10'h317};
  dcpmc_cores u_dcpmc_cores (.clk_in(clk_sys_in), .cmd_in(cmd),
    .pins_out(pin));
  dcpmc_top u_dcpmc_top (.clk_sys_in(clk_sys_in), .srst_in(srst_in),
    .ce_in(ce), .wait_for_interrupt_instruction_in(pin[1:0]),
    .wait_for_event_instruction_in(pin[3:2]), .pd_enable_in(pin[5:4]),
    .pd_sel_core0_in(pin[7:6]), .pd_sel_core1_in(pin[9:8]),
    .wake_in(pin[11:10]), .core_clk_en_out(clk_en),
    .periph_power_en_out(periph), .mem_power_en_out(mem),
    .pd_grant_out(grant), .mode_out(mode));
  initial forever #5 clk_sys_in = ~clk_sys_in;
  task cyc(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask
  task chk(input string n, input logic [2:0] e, input logic [2:0] g);
    checked++;
    if (g !== e)
    begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  task wake(input logic [1:0] w);
    cmd[11:10] = w;
    cyc(2);
    cmd[11:10] = 2'h0;
    cyc(2);
  endtask
  task end_of_test;
    if (fail_count == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    #5000;
    fail_count++;
    end_of_test();
  end
  initial
  begin
    repeat (20) @(negedge clk_sys_in);
    srst_in = 1'b0;
    cyc(1);
    chk("reset", 3'h3, {grant, clk_en});
    chk("reset mode", 3'h0, mode);
    foreach (rows[i])
    begin
      cmd = {2'h0, rows[i][7:4], rows[i][9:8], 2'h0, rows[i][9:8]};
      cyc(1);
      cmd[1:0] = 2'h0;
      cyc(3);
      chk("mode", rows[i][3:1], mode);
      chk("mem", {2'h0, rows[i][0]}, {2'h0, mem});
      chk("off", 3'h4, {grant, periph, 1'h0} | {1'h0, clk_en});
      wake(2'h3);
      chk("awake", 3'h3, {1'h0, clk_en});
    end
    // both select power-down; the later waiter sets the selection
    cmd = 12'h171;
    cyc(1);
    cmd[1:0] = 2'h0;
    cyc(3);
    chk("one asleep", 3'h2, {grant, clk_en});
    cmd[3] = 1'b1;
    cyc(1);
    cmd[3] = 1'b0;
    cyc(3);
    chk("both waited", 3'h3, mode);
    wake(2'h3);
    cmd = 12'h003;
    cyc(1);
    cmd = 12'h0;
    cyc(3);
    chk("not enabled", 3'h2, {grant, periph, clk_en[0] | clk_en[1]});
    wake(2'h3);
    // clock enable low freezes the core state
    @(negedge clk_sys_in);
    ce = 1'b0;
    cyc(1);
    cmd = 12'h001;
    cyc(3);
    chk("frozen", 3'h3, {1'h0, clk_en});
    cmd = 12'h0;
    cyc(2);
    @(negedge clk_sys_in);
    ce = 1'b1;
    cyc(2);
    chk("thawed", 3'h3, {1'h0, clk_en});
    // reset in the middle of a power-down
    cmd = 12'h051;
    cyc(1);
    cmd[1:0] = 2'h0;
    cyc(3);
    chk("solo pd", 3'h4, {grant, clk_en});
    @(negedge clk_sys_in);
    srst_in = 1'b1;
    cmd = 12'h0;
    repeat (2) @(negedge clk_sys_in);
    srst_in = 1'b0;
    cyc(1);
    chk("rereset", 3'h3, {grant, clk_en});
    chk("rereset power", 3'h3, {1'h0, periph, mem});
    chk("rereset mode", 3'h0, mode);
    end_of_test();
  end
endmodule
`default_nettype wire
